// [common/ihc_pkg.sv]
// shared constants and types for the init, halt and input control block
package ihc_pkg;
    localparam int CYC_PULSES = 6;
    localparam logic [2:0] PHASE_LAST = 3'h5;
    localparam logic [2:0] PHASE_FIRST = 3'h0;
    localparam int RST_MIN_CYC = 6;
    localparam logic [2:0] RST_MIN_CNT = 3'h6;
    localparam int R_NUM_SMALL = 10;
    localparam int R_NUM_LARGE = 16;
    localparam int O_WIDTH = 8;
    localparam int IN_WIDTH = 4;
    localparam logic [15:0] R_RESET = 16'h0000;
    localparam logic [7:0] O_RESET = 8'h00;
    localparam logic [3:0] BUS_RESET = 4'h0;

    typedef enum logic [1:0] {
        IHC_PWRUP = 2'b00,
        IHC_RUN = 2'b01,
        IHC_RST = 2'b10,
        IHC_HALT = 2'b11
    } ihc_state_e;

    // one instruction's request to the i/o side, valid at the cycle's last phase
    typedef struct packed {
        logic in_req;
        logic in_to_acc;
        logic r_set;
        logic r_clr;
        logic [3:0] r_addr;
        logic o_load;
        logic [7:0] o_data;
    } ihc_req_s;
endpackage

// [logic/ihc_sync.sv]
// two-stage synchroniser for asynchronous control levels
`timescale 1ns/1ns
`default_nettype none
module ihc_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    always_comb begin
        meta_d = ce ? d : meta_q;
        q_d = ce ? meta_q : q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule
`default_nettype wire

// [logic/ihc_ctrl.sv]
// instruction-cycle timing, power-up/restart, halt and input port steering
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - six clock pulses form one instruction cycle
// - init clears page, counter, R and O latches
// - power-up ignores K; reset expects K low
// - restart release after six or more cycles resets program address
// - restart high holds R and O latches reset
// - standby request halts at cycle end
// - halt keeps every output unchanged
// - standby release resumes at next address
// - restart forces internal standby request low
// - input request routes selected port to adder
// - input word is tested or loaded to accumulator
// - two input ports share one internal bus
// - select low picks primary port
// - select high picks secondary port
// - latch mode low gives pass mode
// - 10 or 16 addressed output latches
// - eight-bit parallel latch, loaded as a word
// - latch mode high captures secondary pulses
// - bus latches reset, pass or hold per mode
module ihc_ctrl #(
    parameter int R_NUM = ihc_pkg::R_NUM_LARGE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic restart_req,
    input wire logic standby_req,
    input wire logic port_select,
    input wire logic latch_mode_select,
    input wire logic [3:0] k_in,
    input wire logic [3:0] l_in,
    input wire ihc_pkg::ihc_req_s req,
    output logic [2:0] phase_q,
    output logic cyc_end_q,
    output logic run_q,
    output logic halted_q,
    output logic pc_clear_q,
    output logic [3:0] in_bus_q,
    output logic acc_load_q,
    output logic [3:0] acc_data_q,
    output logic test_q,
    output logic test_hit_q,
    output logic [R_NUM-1:0] r_out_q,
    output logic [7:0] o_out_q
);
    generate
        if (R_NUM != ihc_pkg::R_NUM_SMALL && R_NUM != ihc_pkg::R_NUM_LARGE) begin : g_bad_rnum
            $error("R_NUM must be 10 or 16");
        end
    endgenerate

    logic restart_s;
    logic standby_s;
    logic standby_eff;
    logic cyc_end;
    ihc_pkg::ihc_state_e st_q, st_d;
    logic [2:0] phase_d;
    logic [2:0] rcnt_q, rcnt_d;
    logic cyc_end_d, run_d, halted_d, pc_clear_d;
    logic [3:0] sense_q, sense_d;
    logic [3:0] in_bus_d, acc_data_d;
    logic acc_load_d, test_d, test_hit_d;
    logic [R_NUM-1:0] r_out_d;
    logic [7:0] o_out_d;

    ihc_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({restart_req, standby_req}),
        .q({restart_s, standby_s})
    );

    assign standby_eff = standby_s & ~restart_s;
    assign cyc_end = (phase_q == ihc_pkg::PHASE_LAST);

    // cycle phase, restart timing and mode sequencing
    always_comb begin
        phase_d = phase_q;
        rcnt_d = rcnt_q;
        st_d = st_q;
        // a frozen clock enable keeps the clear pulse standing as well
        pc_clear_d = ce ? 1'b0 : pc_clear_q;
        if (ce) begin
            if (st_q == ihc_pkg::IHC_HALT) begin
                phase_d = ihc_pkg::PHASE_FIRST;
            end else if (cyc_end) begin
                phase_d = ihc_pkg::PHASE_FIRST;
            end else begin
                phase_d = phase_q + 3'h1;
            end
            if (restart_s) begin
                st_d = ihc_pkg::IHC_RST;
                if (cyc_end && rcnt_q < ihc_pkg::RST_MIN_CNT) begin
                    rcnt_d = rcnt_q + 3'h1;
                end
            end else begin
                rcnt_d = 3'h0;
                unique case (st_q)
                    ihc_pkg::IHC_PWRUP: begin
                        if (cyc_end) begin
                            st_d = ihc_pkg::IHC_RUN;
                            pc_clear_d = 1'b1;
                        end
                    end
                    ihc_pkg::IHC_RST: begin
                        st_d = ihc_pkg::IHC_RUN;
                        phase_d = ihc_pkg::PHASE_FIRST;
                        pc_clear_d = (rcnt_q >= ihc_pkg::RST_MIN_CNT);
                    end
                    ihc_pkg::IHC_RUN: begin
                        if (cyc_end && standby_eff) begin
                            st_d = ihc_pkg::IHC_HALT;
                        end
                    end
                    ihc_pkg::IHC_HALT: begin
                        if (!standby_eff) begin
                            st_d = ihc_pkg::IHC_RUN;
                        end
                    end
                endcase
            end
        end
        cyc_end_d = (phase_d == ihc_pkg::PHASE_LAST) && (st_d != ihc_pkg::IHC_HALT);
        run_d = (st_d == ihc_pkg::IHC_RUN);
        halted_d = (st_d == ihc_pkg::IHC_HALT);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ihc_pkg::IHC_PWRUP;
            phase_q <= ihc_pkg::PHASE_FIRST;
            rcnt_q <= 3'h0;
            cyc_end_q <= 1'b0;
            run_q <= 1'b0;
            halted_q <= 1'b0;
            pc_clear_q <= 1'b0;
        end else begin
            st_q <= st_d;
            phase_q <= phase_d;
            rcnt_q <= rcnt_d;
            cyc_end_q <= cyc_end_d;
            run_q <= run_d;
            halted_q <= halted_d;
            pc_clear_q <= pc_clear_d;
        end
    end

    // secondary port sense latches: pass when mode low, catch highs when mode high
    genvar gi;
    generate
        for (gi = 0; gi < ihc_pkg::IN_WIDTH; gi++) begin : g_sense
            always_comb begin
                sense_d[gi] = sense_q[gi];
                if (ce) begin
                    if (latch_mode_select) begin
                        sense_d[gi] = sense_q[gi] | l_in[gi];
                    end else begin
                        sense_d[gi] = l_in[gi];
                    end
                end
            end
        end
    endgenerate

    // input bus steering and the adder-side answer
    always_comb begin
        in_bus_d = in_bus_q;
        acc_load_d = 1'b0;
        acc_data_d = acc_data_q;
        test_d = 1'b0;
        test_hit_d = test_hit_q;
        if (!ce) begin
            acc_load_d = acc_load_q;
            test_d = test_q;
        end else if (st_q == ihc_pkg::IHC_PWRUP) begin
            in_bus_d = ihc_pkg::BUS_RESET;
        end else if (st_q != ihc_pkg::IHC_HALT) begin
            in_bus_d = port_select ? sense_q : k_in;
            if (st_q == ihc_pkg::IHC_RUN && !restart_s && cyc_end && req.in_req) begin
                if (req.in_to_acc) begin
                    acc_load_d = 1'b1;
                    acc_data_d = in_bus_q;
                end else begin
                    test_d = 1'b1;
                    test_hit_d = |in_bus_q;
                end
            end
        end
    end

    // addressed and parallel output latches
    always_comb begin
        r_out_d = r_out_q;
        o_out_d = o_out_q;
        if (ce) begin
            if (restart_s || st_q == ihc_pkg::IHC_PWRUP) begin
                r_out_d = ihc_pkg::R_RESET[R_NUM-1:0];
                o_out_d = ihc_pkg::O_RESET;
            end else if (st_q == ihc_pkg::IHC_RUN && cyc_end) begin
                if (int'(req.r_addr) < R_NUM) begin
                    if (req.r_set) begin
                        r_out_d[req.r_addr] = 1'b1;
                    end else if (req.r_clr) begin
                        r_out_d[req.r_addr] = 1'b0;
                    end
                end
                if (req.o_load) begin
                    o_out_d = req.o_data;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sense_q <= ihc_pkg::BUS_RESET;
            in_bus_q <= ihc_pkg::BUS_RESET;
            acc_load_q <= 1'b0;
            acc_data_q <= ihc_pkg::BUS_RESET;
            test_q <= 1'b0;
            test_hit_q <= 1'b0;
            r_out_q <= ihc_pkg::R_RESET[R_NUM-1:0];
            o_out_q <= ihc_pkg::O_RESET;
        end else begin
            sense_q <= sense_d;
            in_bus_q <= in_bus_d;
            acc_load_q <= acc_load_d;
            acc_data_q <= acc_data_d;
            test_q <= test_d;
            test_hit_q <= test_hit_d;
            r_out_q <= r_out_d;
            o_out_q <= o_out_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_phase_wrap: assert property (ce && cyc_end && st_q == ihc_pkg::IHC_RUN && !restart_s
        |=> phase_q == ihc_pkg::PHASE_FIRST) else $error("phase did not wrap after six");
    a_phase_range: assert property (phase_q <= ihc_pkg::PHASE_LAST)
        else $error("phase out of range");
    a_restart_outs: assert property (ce && restart_s
        |=> r_out_q == '0 && o_out_q == 8'h00) else $error("outputs not held reset");
    a_restart_clear: assert property (ce && st_q == ihc_pkg::IHC_RST && !restart_s
        && rcnt_q >= ihc_pkg::RST_MIN_CNT |=> pc_clear_q ##1 (!pc_clear_q || !$past(ce)))
        else $error("restart release missed address clear");
    a_short_restart: assert property (ce && st_q == ihc_pkg::IHC_RST && !restart_s
        && rcnt_q < ihc_pkg::RST_MIN_CNT |=> !pc_clear_q) else $error("short restart cleared");
    a_halt_entry: assert property (ce && st_q == ihc_pkg::IHC_RUN && cyc_end && standby_eff
        |=> halted_q && !run_q) else $error("halt not entered at cycle end");
    a_halt_hold: assert property (st_q == ihc_pkg::IHC_HALT && !restart_s
        |=> $stable(r_out_q) && $stable(o_out_q) && $stable(acc_data_q))
        else $error("output moved in halt");
    a_halt_exit: assert property (ce && st_q == ihc_pkg::IHC_HALT && !standby_s && !restart_s
        |=> run_q && !pc_clear_q) else $error("halt exit wrong");
    a_reset_wins: assert property (ce && restart_s && standby_s
        |=> !halted_q && st_q == ihc_pkg::IHC_RST) else $error("halt beat restart");
    a_pwrup_ignore: assert property (ce && st_q == ihc_pkg::IHC_PWRUP
        |=> in_bus_q == 4'h0) else $error("input seen in power-up");
    a_port_pick: assert property (ce && st_q == ihc_pkg::IHC_RUN && !port_select
        |=> in_bus_q == $past(k_in)) else $error("primary port not selected");
    a_acc_load: assert property (ce && st_q == ihc_pkg::IHC_RUN && !restart_s && cyc_end
        && req.in_req && req.in_to_acc |=> acc_load_q && acc_data_q == $past(in_bus_q))
        else $error("input word not loaded");

    c_halt_cycle: cover property (halted_q ##[1:20] run_q);
    c_full_restart: cover property (pc_clear_q && $past(st_q) == ihc_pkg::IHC_RST);
    c_sense_catch: cover property (latch_mode_select && port_select && $fell(l_in[0]));
    c_test_hit: cover property (test_q && test_hit_q);
endmodule
`default_nettype wire

// [bench/ihc_partner.sv]
// far-side model: restart and halt sources, key and sense ports
`timescale 1ns/1ns
`default_nettype none
module ihc_partner (
    input wire logic clk,
    output logic restart_req,
    output logic standby_req,
    output logic [3:0] k_in,
    output logic [3:0] l_in
);
    initial begin
        restart_req = 1'b0;
        standby_req = 1'b0;
        k_in = 4'h0;
        l_in = 4'h0;
    end
    task automatic set_in(input logic [3:0] k, input logic [3:0] l);
        k_in <= k;
        l_in <= l;
    endtask
    task automatic halt(input logic v);
        standby_req <= v;
    endtask
    task automatic pulse_l(input logic [3:0] v);
        l_in <= v;
        @(negedge clk);
        l_in <= 4'h0;
    endtask
    task automatic restart(input int cyc);
        k_in <= 4'h0;
        restart_req <= 1'b1;
        repeat (cyc * 6 + 4) @(negedge clk);
        restart_req <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [bench/ihc_ctrl_tb.sv]
// self-checking bench for the init, halt and input control block
`timescale 1ns/1ns
`default_nettype none
module ihc_ctrl_tb;
    logic clk, rst, ce, psel, lmode, restart_req, standby_req, cyc_end_q, run_q, halted_q;
    logic pc_clear_q, acc_load_q, test_q, test_hit_q;
    logic [2:0] phase_q;
    logic [3:0] k_in, l_in, in_bus_q, acc_data_q;
    logic [15:0] r_out_q;
    logic [7:0] o_out_q;
    ihc_pkg::ihc_req_s req;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int pcc = 0;
    int n, i;
    ihc_ctrl ihc_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .restart_req(restart_req), .standby_req(standby_req),
        .port_select(psel), .latch_mode_select(lmode), .k_in(k_in), .l_in(l_in), .req(req), .phase_q(phase_q),
        .cyc_end_q(cyc_end_q), .run_q(run_q), .halted_q(halted_q), .pc_clear_q(pc_clear_q), .in_bus_q(in_bus_q),
        .acc_load_q(acc_load_q), .acc_data_q(acc_data_q), .test_q(test_q), .test_hit_q(test_hit_q),
        .r_out_q(r_out_q), .o_out_q(o_out_q));
    ihc_partner ihc_partner_i (.clk(clk), .restart_req(restart_req), .standby_req(standby_req), .k_in(k_in),
        .l_in(l_in));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // counts address-clear pulses away from the launching edge and cuts a hang short
    always @(negedge clk) begin
        cycles++;
        if (pc_clear_q === 1'b1) pcc++;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // presents one request at the cycle-end edge, returns once its effect is visible
    task automatic issue(input logic [16:0] v);
        for (n = 0; n < 12 && cyc_end_q !== 1'b1; n++) @(negedge clk);
        req = ihc_pkg::ihc_req_s'(v);
        @(negedge clk);
        req = '0;
    endtask
    task automatic inp(input logic s, input logic m, input logic [3:0] k, input logic [3:0] l,
        input logic acc, input logic [3:0] p, input logic [3:0] e);
        psel = s;
        lmode = m;
        ihc_partner_i.set_in(k, l);
        @(negedge clk);
        if (p != 4'h0) ihc_partner_i.pulse_l(p);
        repeat (3) @(negedge clk);
        issue({1'b1, acc, 15'h0000});
        if (acc) chk(16'({acc_load_q, acc_data_q}), 16'({1'b1, e}));
        else chk(16'({test_q, test_hit_q}), 16'({1'b1, e[0]}));
    endtask
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        lmode = 1'b0;
        req = '0;
        ihc_partner_i.set_in(4'hf, 4'hf);
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(16'({run_q, in_bus_q}), 16'h0000);
        for (n = 0; n < 12 && run_q !== 1'b1; n++) @(negedge clk);
        repeat (2) @(negedge clk);
        chk(16'(pcc), 16'h0001);
        issue(17'h00000);
        for (i = 0; i < 12; i++) begin
            chk(16'({cyc_end_q, phase_q}), 16'({i % 6 == 5, 3'(i % 6)}));
            @(negedge clk);
        end
        $display("test power-up and timing done");
        issue({4'b0010, 4'hf, 1'b1, 8'ha5});
        chk(r_out_q, 16'h8000);
        chk(16'(o_out_q), 16'h00a5);
        issue({4'b0011, 4'h0, 9'h000});
        issue({4'b0001, 4'hf, 9'h000});
        chk(r_out_q, 16'h0001);
        chk(16'(o_out_q), 16'h00a5);
        $display("test output latches done");
        // clock enable low at a cycle end: phase and latches freeze, the request waits
        for (n = 0; n < 12 && cyc_end_q !== 1'b1; n++) @(negedge clk);
        ce = 1'b0;
        req = ihc_pkg::ihc_req_s'({4'b0010, 4'h1, 9'h000});
        repeat (4) @(negedge clk);
        chk(16'({run_q, cyc_end_q, phase_q}), 16'h001d);
        chk(r_out_q, 16'h0001);
        ce = 1'b1;
        @(negedge clk);
        req = '0;
        chk(r_out_q, 16'h0003);
        chk(16'(phase_q), 16'h0000);
        issue({4'b0001, 4'h1, 9'h000});
        chk(r_out_q, 16'h0001);
        $display("test clock enable done");
        inp(1'b0, 1'b0, 4'h5, 4'h9, 1'b1, 4'h0, 4'h5);
        inp(1'b1, 1'b0, 4'h5, 4'h9, 1'b1, 4'h0, 4'h9);
        inp(1'b0, 1'b1, 4'h3, 4'h0, 1'b0, 4'h0, 4'h1);
        inp(1'b1, 1'b0, 4'h5, 4'h0, 1'b0, 4'h0, 4'h0);
        inp(1'b1, 1'b1, 4'h0, 4'h0, 1'b1, 4'h6, 4'h6);
        inp(1'b1, 1'b0, 4'h0, 4'h0, 1'b1, 4'h6, 4'h0);
        $display("test input steering done");
        ihc_partner_i.halt(1'b1);
        for (n = 0; n < 12 && halted_q !== 1'b1; n++) @(negedge clk);
        chk(16'(halted_q), 16'h0001);
        i = pcc;
        req = ihc_pkg::ihc_req_s'({4'b0010, 4'h4, 1'b1, 8'h3c});
        repeat (8) @(negedge clk);
        chk(16'({cyc_end_q, o_out_q}), 16'h00a5);
        chk(r_out_q, 16'h0001);
        req = '0;
        ihc_partner_i.halt(1'b0);
        for (n = 0; n < 6 && run_q !== 1'b1; n++) @(negedge clk);
        chk(16'({run_q, phase_q}), 16'h0008);
        repeat (2) @(negedge clk);
        chk(16'(pcc - i), 16'h0000);
        $display("test halt done");
        ihc_partner_i.halt(1'b1);
        repeat (12) @(negedge clk);
        i = pcc;
        fork
            ihc_partner_i.restart(7);
            begin
                repeat (8) @(negedge clk);
                chk(16'({halted_q, run_q, o_out_q}), 16'h0000);
                chk(r_out_q, 16'h0000);
            end
        join
        ihc_partner_i.halt(1'b0);
        for (n = 0; n < 6 && run_q !== 1'b1; n++) @(negedge clk);
        repeat (2) @(negedge clk);
        chk(16'(pcc - i), 16'h0001);
        issue({4'b0010, 4'h2, 9'h000});
        chk(r_out_q, 16'h0004);
        i = pcc;
        ihc_partner_i.restart(2);
        repeat (4) @(negedge clk);
        chk(r_out_q, 16'h0000);
        chk(16'(pcc - i), 16'h0000);
        $display("test restart done");
        print_verdict();
    end
endmodule
`default_nettype wire
